// >>> hw/tsh_map.svh
// What this block does
// [RQ1] Host reaches device over I2C or HID-I2C.
// [RQ2] After power-up, change line falls: data waiting.
// [RQ3] Host times out waiting for change line.
// [RQ4] Host reads 7 identification bytes from zero.
// [RQ5] Host keeps identification bytes for directory walk.
// [RQ6] Device checksums stored configuration against saved copy.
// [RQ7] Host rewrites configuration and backs up on mismatch.
// [RQ8] Host reads every object start from directory.
// [RQ9] Host derives report ID ranges per object.
// [RQ10] Host drains all start-up messages last.
// [RQ11] Message object holds one readable message.
// [RQ12] Command object executes reset, calibrate, backup writes.
// [RQ13] Power object sets acquisition and sleep intervals.
`ifndef TSH_MAP_SVH
`define TSH_MAP_SVH
// memory map of the device
`define TSH_ID_BASE 16'h0000
`define TSH_ID_LEN 7
`define TSH_OT_BASE 16'h0007
`define TSH_OT_ENTRY 6
`define TSH_NUM_OBJ 8'h04
`define TSH_MSG_ADDR 16'h0020
`define TSH_MSG_LEN 3
`define TSH_CMD_ADDR 16'h0030
`define TSH_CMD_LEN 4
`define TSH_PWR_ADDR 16'h0038
`define TSH_ACQ_ADDR 16'h003c
`define TSH_CFG_LEN 2
// object type codes and report ids
`define TSH_TY_MSG 8'h05
`define TSH_TY_CMD 8'h06
`define TSH_TY_PWR 8'h07
`define TSH_TY_ACQ 8'h08
`define TSH_CMD_RID 8'h01
`define TSH_RID_NONE 8'hff
// command object field offsets and backup key
`define TSH_CMD_RESET 2'h0
`define TSH_CMD_BACKUP 2'h1
`define TSH_CMD_CALIB 2'h2
`define TSH_BACKUP_KEY 8'h55
// command message status bits
`define TSH_ST_RESET 7
`define TSH_ST_CAL 4
`define TSH_ST_CFGERR 3
// configuration reset values and saved checksum
`define TSH_CFG_IDLE_RST 8'h00
`define TSH_CFG_ACT_RST 8'h00
`define TSH_CFG_ACQ_RST 8'h00
`define TSH_NV_SUM_RST 8'h00
// timing
`define TSH_CLK_KHZ 10000
`define TSH_MS_CYC (`TSH_CLK_KHZ)
`define TSH_POWER_ON_SELF_TEST_US 10
`define TSH_POWER_ON_SELF_TEST_CYC ((`TSH_POWER_ON_SELF_TEST_US * `TSH_CLK_KHZ + 999) / 1000)
`define TSH_CHG_TMO_MS 1300
`define TSH_CHG_TMO_CYC (`TSH_CHG_TMO_MS * `TSH_CLK_KHZ)
`endif

// >>> hw/tsh_pkg.sv
package tsh_pkg;
   typedef logic [7:0] tsh_byte_t;
   // device start-up states
   typedef enum logic [1:0] {
      TSH_D_POWER_ON_SELF_TEST = 2'h0,
      TSH_D_SUM = 2'h1,
      TSH_D_RUN = 2'h3
   } tsh_dev_st_t;
   // host bring-up states
   typedef enum logic [2:0] {
      TSH_H_WAIT = 3'h0,
      TSH_H_RD_ID = 3'h1,
      TSH_H_RD_OT = 3'h3,
      TSH_H_DRAIN = 3'h2,
      TSH_H_WR_CFG = 3'h6,
      TSH_H_WR_BKP = 3'h7,
      TSH_H_READY = 3'h5,
      TSH_H_FAULT = 3'h4
   } tsh_host_st_t;
endpackage

// >>> hw/tsh_link_if.sv
`timescale 1ns/1ns
interface tsh_link_if;
   logic chg_n;
   logic req;
   logic we;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   modport dev (output chg_n, input req, input we, input addr, input wdata, output ack,
      output rdata);
   modport host (input chg_n, output req, output we, output addr, output wdata, input ack,
      input rdata);
endinterface

// >>> hw/tsh_device.sv
`timescale 1ns/1ns
`include "tsh_map.svh"
module tsh_device #(
   parameter int POWER_ON_SELF_TEST_CYC = `TSH_POWER_ON_SELF_TEST_CYC,
   parameter int MS_CYC = `TSH_MS_CYC,
   parameter logic [7:0] FAMILY_ID = 8'ha5, // arbitrary value
   parameter logic [7:0] VARIANT_ID = 8'h3c, // arbitrary value
   parameter logic [7:0] VERSION_ID = 8'h10, // arbitrary value
   parameter logic [7:0] BUILD_ID = 8'h01, // arbitrary value
   parameter logic [7:0] MATRIX_X = 8'h10,
   parameter logic [7:0] MATRIX_Y = 8'h0c
) (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // link to host
   tsh_link_if.dev lnk,
   // strap and user side
   input wire logic hid_sel,
   input wire logic touch_active,
   output logic hid_active,
   output logic running,
   output logic cfg_err,
   output logic acq_pulse,
   output logic cal_pulse
);
   tsh_pkg::tsh_dev_st_t st_q;
   logic [15:0] power_on_self_test_q;
   logic [7:0] cfg_q [4];
   logic [7:0] nv_sum_q;
   logic cfg_err_q, hid_q, ack_q, msg_v_q, pend_q, acq_q, cal_q;
   logic [7:0] rdata_q, msg_st_q, msg_sum_q, pend_st_q, acq_n_q;
   logic [15:0] ms_q;
   logic [1:0] pin_s1_q, pin_s2_q;

   // directory entry: type, start lo, start hi, size-1, instances-1, report ids
   function automatic logic [7:0] ot_byte(input logic [2:0] e, input logic [2:0] f);
      logic [7:0] ty, sz, rids;
      logic [15:0] st;
      ty = `TSH_TY_ACQ;
      st = `TSH_ACQ_ADDR;
      sz = 8'h01;
      rids = 8'h00;
      case (e)
         3'h0: begin
            ty = `TSH_TY_MSG;
            st = `TSH_MSG_ADDR;
            sz = 8'h02;
         end
         3'h1: begin
            ty = `TSH_TY_CMD;
            st = `TSH_CMD_ADDR;
            sz = 8'h03;
            rids = 8'h01;
         end
         3'h2: begin
            ty = `TSH_TY_PWR;
            st = `TSH_PWR_ADDR;
         end
         default: ;
      endcase
      case (f)
         3'h0: ot_byte = ty;
         3'h1: ot_byte = st[7:0];
         3'h2: ot_byte = st[15:8];
         3'h3: ot_byte = sz;
         3'h4: ot_byte = 8'h00;
         default: ot_byte = rids;
      endcase
   endfunction

   // address decode
   wire [15:0] a = lnk.addr;
   wire take = lnk.req & ~ack_q;
   wire [15:0] o_ot = a - `TSH_OT_BASE;
   wire [15:0] o_msg = a - `TSH_MSG_ADDR;
   wire [15:0] o_cmd = a - `TSH_CMD_ADDR;
   wire [15:0] o_pwr = a - `TSH_PWR_ADDR;
   wire [15:0] o_acq = a - `TSH_ACQ_ADDR;
   wire in_id = a < 16'(`TSH_ID_LEN);
   wire in_ot = o_ot < 16'(`TSH_OT_ENTRY * 4);
   wire in_msg = o_msg < 16'(`TSH_MSG_LEN);
   wire in_cmd = o_cmd < 16'(`TSH_CMD_LEN);
   wire in_pwr = o_pwr < 16'(`TSH_CFG_LEN);
   wire in_acq = o_acq < 16'(`TSH_CFG_LEN);
   wire [2:0] ot_e = 3'(o_ot / 16'd6);
   wire [2:0] ot_f = 3'(o_ot % 16'd6);
   wire [1:0] cfg_i = in_pwr ? {1'b0, o_pwr[0]} : {1'b1, o_acq[0]};
   wire [55:0] id_vec = {FAMILY_ID, VARIANT_ID, VERSION_ID, BUILD_ID, MATRIX_X, MATRIX_Y,
      `TSH_NUM_OBJ};
   wire [2:0] id_i = 3'(3'd6 - a[2:0]);
   wire [7:0] msg_byte = (o_msg[1:0] == 2'h0) ? (msg_v_q ? `TSH_CMD_RID : `TSH_RID_NONE) :
      (o_msg[1:0] == 2'h1) ? msg_st_q : msg_sum_q; // RQ11
   wire [7:0] rd_d = in_id ? id_vec[8*id_i+:8] : in_ot ? ot_byte(ot_e, ot_f) :
      in_msg ? msg_byte : (in_pwr | in_acq) ? cfg_q[cfg_i] : 8'h00;

   // commands and writes act only once start-up is over
   wire run = (st_q == tsh_pkg::TSH_D_RUN);
   wire wr = take & lnk.we & run;
   wire cmd_rst = wr & in_cmd & (o_cmd[1:0] == `TSH_CMD_RESET) & (lnk.wdata != 8'h00); // RQ12
   wire cmd_bkp = wr & in_cmd & (o_cmd[1:0] == `TSH_CMD_BACKUP)
      & (lnk.wdata == `TSH_BACKUP_KEY); // RQ12
   wire cmd_cal = wr & in_cmd & (o_cmd[1:0] == `TSH_CMD_CALIB) & (lnk.wdata != 8'h00); // RQ12
   wire cfg_wr = wr & (in_pwr | in_acq);
   wire [7:0] cfg_sum = cfg_q[0] + cfg_q[1] + cfg_q[2] + cfg_q[3]; // RQ6

   // message queue: one held message, further events wait as pending bits
   wire in_sum = (st_q == tsh_pkg::TSH_D_SUM);
   wire pop = take & ~lnk.we & in_msg & (o_msg[1:0] == 2'h2) & msg_v_q; // RQ11
   wire load = pend_q & ~msg_v_q;
   wire ev = in_sum | cmd_cal | cmd_bkp;
   wire [7:0] ev_st = (in_sum ? 8'h80 : 8'h00) | (cmd_cal ? 8'h10 : 8'h00);

   // link answer: one-cycle ack after each taken request
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ack_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         ack_q <= take;
         if (take) begin
            rdata_q <= rd_d;
         end
      end
   end

   // pins are asynchronous: two flops before any logic reads them
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pin_s1_q <= 2'h0;
         pin_s2_q <= 2'h0;
      end else begin
         pin_s1_q <= {touch_active, hid_sel};
         pin_s2_q <= pin_s1_q;
      end
   end

   // mode strap caught after release, never under reset itself
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         hid_q <= 1'b0;
      end else if (st_q == tsh_pkg::TSH_D_POWER_ON_SELF_TEST) begin
         hid_q <= pin_s2_q[0]; // RQ1
      end
   end

   // start-up: self test wait, checksum, then run
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= tsh_pkg::TSH_D_POWER_ON_SELF_TEST;
         power_on_self_test_q <= 16'h0000;
         cfg_err_q <= 1'b0;
      end else begin
         case (st_q)
            tsh_pkg::TSH_D_POWER_ON_SELF_TEST: begin
               power_on_self_test_q <= power_on_self_test_q + 16'h0001;
               if (power_on_self_test_q == 16'(POWER_ON_SELF_TEST_CYC - 1)) begin
                  st_q <= tsh_pkg::TSH_D_SUM;
               end
            end
            tsh_pkg::TSH_D_SUM: begin
               cfg_err_q <= (cfg_sum != nv_sum_q); // RQ6
               st_q <= tsh_pkg::TSH_D_RUN;
            end
            tsh_pkg::TSH_D_RUN: begin
               if (cmd_rst) begin
                  st_q <= tsh_pkg::TSH_D_POWER_ON_SELF_TEST;
                  power_on_self_test_q <= 16'h0000;
               end else if (cmd_bkp) begin
                  cfg_err_q <= 1'b0;
               end
            end
            default: st_q <= tsh_pkg::TSH_D_POWER_ON_SELF_TEST;
         endcase
      end
   end

   // configuration and its saved checksum survive a soft reset
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_q[0] <= `TSH_CFG_IDLE_RST;
         cfg_q[1] <= `TSH_CFG_ACT_RST;
         cfg_q[2] <= `TSH_CFG_ACQ_RST;
         cfg_q[3] <= `TSH_CFG_ACQ_RST;
         nv_sum_q <= `TSH_NV_SUM_RST;
      end else begin
         if (cfg_wr) begin
            cfg_q[cfg_i] <= lnk.wdata;
         end
         if (cmd_bkp) begin
            nv_sum_q <= cfg_sum; // RQ12
         end
      end
   end

   // a new event wins over the load that empties the pending bits
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         msg_v_q <= 1'b0;
         pend_q <= 1'b0;
         pend_st_q <= 8'h00;
         msg_st_q <= 8'h00;
         msg_sum_q <= 8'h00;
      end else if (cmd_rst) begin
         msg_v_q <= 1'b0;
         pend_q <= 1'b0;
         pend_st_q <= 8'h00;
      end else begin
         pend_q <= (pend_q & ~load) | ev;
         pend_st_q <= (load ? 8'h00 : pend_st_q) | ev_st;
         if (load) begin
            msg_v_q <= 1'b1; // RQ2
            msg_st_q <= pend_st_q | {4'h0, cfg_err_q, 3'h0};
            msg_sum_q <= nv_sum_q;
         end else if (pop) begin
            msg_v_q <= 1'b0;
         end
      end
   end

   // acquisition pacing: ms enable, interval 0 means sleep with no acquisition
   wire ms_tick = (ms_q == 16'(MS_CYC - 1));
   wire [7:0] ivl = pin_s2_q[1] ? cfg_q[1] : cfg_q[0];
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ms_q <= 16'h0000;
         acq_n_q <= 8'h00;
         acq_q <= 1'b0;
         cal_q <= 1'b0;
      end else begin
         ms_q <= ms_tick ? 16'h0000 : ms_q + 16'h0001;
         cal_q <= cmd_cal;
         acq_q <= 1'b0;
         if (run & ms_tick & (ivl != 8'h00)) begin
            if (acq_n_q + 8'h01 >= ivl) begin
               acq_n_q <= 8'h00;
               acq_q <= 1'b1; // RQ13
            end else begin
               acq_n_q <= acq_n_q + 8'h01;
            end
         end
      end
   end

   // outputs
   assign lnk.chg_n = ~msg_v_q; // RQ2
   assign lnk.ack = ack_q;
   assign lnk.rdata = rdata_q;
   assign hid_active = hid_q;
   assign running = run;
   assign cfg_err = cfg_err_q;
   assign acq_pulse = acq_q;
   assign cal_pulse = cal_q;
endmodule

// >>> hw/tsh_host.sv
`timescale 1ns/1ns
`include "tsh_map.svh"
module tsh_host #(
   parameter int TMO_CYC = `TSH_CHG_TMO_CYC,
   parameter int MAX_OBJ = 8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // link to device
   tsh_link_if.host lnk,
   // configuration to load: idle ivl, active ivl, acq byte 0, acq byte 1
   input wire logic [31:0] cfg_bytes,
   // bring-up status
   output logic ready,
   output logic fault,
   output logic cfg_fixed,
   output logic [55:0] id_info,
   // received messages
   output logic msg_valid,
   output logic [7:0] msg_rid,
   output logic [7:0] msg_type,
   output logic [7:0] msg_stat,
   output logic [7:0] msg_sum
);
   tsh_pkg::tsh_host_st_t st_q;
   logic req_q, ready_q, fault_q, need_fix_q, fixed_q;
   logic [31:0] tmo_q;
   logic [2:0] idx_q, fld_q;
   logic [7:0] ent_q, otn_q, rid_next_q, lo_q, ty_q, inst_q, mr_q, ms_q;
   logic [55:0] id_q;
   logic [15:0] msg_a_q, cmd_a_q, pwr_a_q, acq_a_q;
   logic [7:0] ot_ty_q [MAX_OBJ];
   logic [7:0] ot_lo_q [MAX_OBJ];
   logic [7:0] ot_hi_q [MAX_OBJ];
   logic mv_q;
   logic [7:0] mrid_q, mtype_q, mstat_q, msum_q;

   // link transfer: held until ack, one idle cycle between transfers
   wire go = req_q & lnk.ack;
   wire xfer = (st_q == tsh_pkg::TSH_H_RD_ID) | (st_q == tsh_pkg::TSH_H_RD_OT)
      | (st_q == tsh_pkg::TSH_H_DRAIN) | (st_q == tsh_pkg::TSH_H_WR_CFG)
      | (st_q == tsh_pkg::TSH_H_WR_BKP);
   wire wr_st = (st_q == tsh_pkg::TSH_H_WR_CFG) | (st_q == tsh_pkg::TSH_H_WR_BKP);
   wire [7:0] num_obj = id_q[7:0]; // RQ5
   wire [7:0] last_ent = (num_obj > 8'(MAX_OBJ)) ? 8'(MAX_OBJ - 1) : num_obj - 8'h01;
   wire [7:0] exp_sum = cfg_bytes[7:0] + cfg_bytes[15:8] + cfg_bytes[23:16]
      + cfg_bytes[31:24];
   wire [15:0] ix16 = {13'h0000, idx_q};

   // address and data per state
   wire [15:0] cfg_addr = (idx_q < 3'h2) ? pwr_a_q + ix16 : acq_a_q + ix16 - 16'h0002;
   wire [15:0] addr_w =
      (st_q == tsh_pkg::TSH_H_RD_ID) ? `TSH_ID_BASE + ix16 : // RQ4
      (st_q == tsh_pkg::TSH_H_RD_OT) ? `TSH_OT_BASE + {8'h00, otn_q} : // RQ8
      (st_q == tsh_pkg::TSH_H_WR_CFG) ? cfg_addr :
      (st_q == tsh_pkg::TSH_H_WR_BKP) ? cmd_a_q + {14'h0000, `TSH_CMD_BACKUP} :
      msg_a_q + ix16;
   wire [7:0] wdata_w = (st_q == tsh_pkg::TSH_H_WR_BKP) ? `TSH_BACKUP_KEY :
      cfg_bytes[8*idx_q[1:0]+:8];

   // report id range of the directory entry being finished
   wire [7:0] rid_cnt = 8'((inst_q + 8'h01) * lnk.rdata);
   wire [7:0] rid_hi = rid_next_q + rid_cnt - 8'h01;

   // map an incoming report id back to its object type
   logic [7:0] lk_type;
   always_comb begin
      lk_type = 8'h00;
      for (int i = 0; i < MAX_OBJ; i++) begin
         if ((8'(i) <= last_ent) && (mr_q >= ot_lo_q[i]) && (mr_q <= ot_hi_q[i])) begin
            lk_type = ot_ty_q[i]; // RQ9
         end
      end
   end

   // message end: last byte taken, empty id ends the drain
   wire msg_end = go & (st_q == tsh_pkg::TSH_H_DRAIN) & (idx_q == 3'h2);
   wire msg_none = (mr_q == `TSH_RID_NONE);
   wire bad_cfg = (lk_type == `TSH_TY_CMD) & (ms_q[`TSH_ST_CFGERR] | (lnk.rdata != exp_sum));

   // request strobe
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         req_q <= 1'b0;
      end else begin
         req_q <= go ? 1'b0 : xfer;
      end
   end

   // bring-up sequence
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= tsh_pkg::TSH_H_WAIT;
         tmo_q <= 32'h0000_0000;
         idx_q <= 3'h0;
         ready_q <= 1'b0;
         fault_q <= 1'b0;
         fixed_q <= 1'b0;
      end else begin
         case (st_q)
            tsh_pkg::TSH_H_WAIT: begin
               tmo_q <= tmo_q + 32'h0000_0001;
               if (!lnk.chg_n) begin
                  st_q <= tsh_pkg::TSH_H_RD_ID; // RQ4
                  idx_q <= 3'h0;
               end else if (tmo_q == 32'(TMO_CYC - 1)) begin
                  st_q <= tsh_pkg::TSH_H_FAULT; // RQ3
                  fault_q <= 1'b1;
               end
            end
            tsh_pkg::TSH_H_RD_ID: begin
               if (go) begin
                  idx_q <= idx_q + 3'h1;
                  if (idx_q == 3'(`TSH_ID_LEN - 1)) begin
                     idx_q <= 3'h0;
                     st_q <= (lnk.rdata == 8'h00) ? tsh_pkg::TSH_H_DRAIN
                        : tsh_pkg::TSH_H_RD_OT;
                  end
               end
            end
            tsh_pkg::TSH_H_RD_OT: begin
               if (go & (fld_q == 3'h5) & (ent_q == last_ent)) begin
                  st_q <= tsh_pkg::TSH_H_DRAIN; // RQ10
               end
            end
            tsh_pkg::TSH_H_DRAIN: begin
               if (go) begin
                  idx_q <= (idx_q == 3'h2) ? 3'h0 : idx_q + 3'h1;
               end
               if (msg_end & msg_none) begin
                  if (ready_q | fixed_q | ~need_fix_q) begin
                     st_q <= tsh_pkg::TSH_H_READY; // RQ10
                     ready_q <= 1'b1;
                  end else begin
                     st_q <= tsh_pkg::TSH_H_WR_CFG; // RQ7
                  end
               end
            end
            tsh_pkg::TSH_H_WR_CFG: begin
               if (go) begin
                  idx_q <= idx_q + 3'h1;
                  if (idx_q == 3'h3) begin
                     idx_q <= 3'h0;
                     st_q <= tsh_pkg::TSH_H_WR_BKP; // RQ7
                  end
               end
            end
            tsh_pkg::TSH_H_WR_BKP: begin
               if (go) begin
                  fixed_q <= 1'b1;
                  st_q <= tsh_pkg::TSH_H_DRAIN;
               end
            end
            tsh_pkg::TSH_H_READY: begin
               if (!lnk.chg_n) begin
                  st_q <= tsh_pkg::TSH_H_DRAIN;
               end
            end
            tsh_pkg::TSH_H_FAULT: ;
            default: st_q <= tsh_pkg::TSH_H_FAULT;
         endcase
      end
   end

   // identification bytes kept for the directory walk
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         id_q <= 56'h0;
      end else if (go & (st_q == tsh_pkg::TSH_H_RD_ID)) begin
         id_q[8*(3'd6 - idx_q)+:8] <= lnk.rdata; // RQ5
      end
   end

   // directory walk: object addresses and report id ranges
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ent_q <= 8'h00;
         fld_q <= 3'h0;
         otn_q <= 8'h00;
         rid_next_q <= 8'h01;
         lo_q <= 8'h00;
         ty_q <= 8'h00;
         inst_q <= 8'h00;
         msg_a_q <= `TSH_MSG_ADDR;
         cmd_a_q <= `TSH_CMD_ADDR;
         pwr_a_q <= `TSH_PWR_ADDR;
         acq_a_q <= `TSH_ACQ_ADDR;
         for (int i = 0; i < MAX_OBJ; i++) begin
            ot_ty_q[i] <= 8'h00;
            ot_lo_q[i] <= 8'hff;
            ot_hi_q[i] <= 8'h00;
         end
      end else if (go & (st_q == tsh_pkg::TSH_H_RD_OT)) begin
         otn_q <= otn_q + 8'h01;
         fld_q <= (fld_q == 3'h5) ? 3'h0 : fld_q + 3'h1;
         case (fld_q)
            3'h0: ty_q <= lnk.rdata;
            3'h1: lo_q <= lnk.rdata;
            3'h2: begin
               if (ty_q == `TSH_TY_MSG) msg_a_q <= {lnk.rdata, lo_q}; // RQ8
               if (ty_q == `TSH_TY_CMD) cmd_a_q <= {lnk.rdata, lo_q}; // RQ8
               if (ty_q == `TSH_TY_PWR) pwr_a_q <= {lnk.rdata, lo_q}; // RQ8
               if (ty_q == `TSH_TY_ACQ) acq_a_q <= {lnk.rdata, lo_q}; // RQ8
            end
            3'h4: inst_q <= lnk.rdata;
            3'h5: begin
               ent_q <= ent_q + 8'h01;
               ot_ty_q[ent_q[2:0]] <= ty_q;
               if (lnk.rdata != 8'h00) begin
                  ot_lo_q[ent_q[2:0]] <= rid_next_q; // RQ9
                  ot_hi_q[ent_q[2:0]] <= rid_hi; // RQ9
                  rid_next_q <= rid_next_q + rid_cnt;
               end
            end
            default: ;
         endcase
      end
   end

   // message capture and checksum check
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mr_q <= 8'h00;
         ms_q <= 8'h00;
         need_fix_q <= 1'b0;
         mv_q <= 1'b0;
         mrid_q <= 8'h00;
         mtype_q <= 8'h00;
         mstat_q <= 8'h00;
         msum_q <= 8'h00;
      end else begin
         mv_q <= 1'b0;
         if (go & (st_q == tsh_pkg::TSH_H_DRAIN) & (idx_q == 3'h0)) mr_q <= lnk.rdata;
         if (go & (st_q == tsh_pkg::TSH_H_DRAIN) & (idx_q == 3'h1)) ms_q <= lnk.rdata;
         if (msg_end & ~msg_none) begin
            mv_q <= 1'b1;
            mrid_q <= mr_q;
            mtype_q <= lk_type; // RQ9
            mstat_q <= ms_q;
            msum_q <= lnk.rdata;
            if (bad_cfg & ~fixed_q) begin
               need_fix_q <= 1'b1; // RQ7
            end
         end
      end
   end

   // outputs
   assign lnk.req = req_q;
   assign lnk.we = wr_st;
   assign lnk.addr = addr_w;
   assign lnk.wdata = wdata_w;
   assign ready = ready_q;
   assign fault = fault_q;
   assign cfg_fixed = fixed_q;
   assign id_info = id_q;
   assign msg_valid = mv_q;
   assign msg_rid = mrid_q;
   assign msg_type = mtype_q;
   assign msg_stat = mstat_q;
   assign msg_sum = msum_q;
endmodule

// >>> tb/tsh_link_assertions.sv
`timescale 1ns/1ns
module tsh_link_assertions #(
   parameter int POWER_ON_SELF_TEST_CYC = 100
) (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // link signals
   input wire logic chg_n,
   input wire logic req,
   input wire logic we,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   int cyc_q;
   logic seen_q;
   // cycles since release, saturating so long runs never wrap
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cyc_q <= 0;
         seen_q <= 1'b0;
      end else begin
         if (cyc_q < 1000)
            cyc_q <= cyc_q + 1;
         if (req)
            seen_q <= 1'b1;
      end
   end
   AST_ACK_AFTER_TAKE: assert property (req && !ack |=> ack)
      else $error("request not answered next cycle");
   AST_ACK_ONE_CYCLE: assert property (ack |=> !ack)
      else $error("answer longer than one cycle");
   AST_ACK_CAUSE: assert property (ack |-> $past(req))
      else $error("answer without request");
   AST_REQ_HOLD: assert property (req && !ack |=> req && $stable(addr) && $stable(we))
      else $error("request changed before answer");
   AST_REQ_DROP: assert property (ack |=> !req)
      else $error("request held past answer");
   AST_RDATA_HOLD: assert property (!$stable(rdata) |-> ack)
      else $error("read data moved outside answer");
   AST_CHG_POWER_ON_SELF_TEST: assert property (cyc_q < POWER_ON_SELF_TEST_CYC |-> chg_n)
      else $error("change line low during self test");
   AST_CHG_FALL: assert property (cyc_q == POWER_ON_SELF_TEST_CYC + 4 |-> !chg_n)
      else $error("change line not low after start-up");
   AST_FIRST_READ: assert property (req && !seen_q |-> !we && addr == 16'h0000)
      else $error("first access not identification read");
   AST_BACKUP_KEY: assert property (req && we && addr == 16'h0031 |-> wdata == 8'h55)
      else $error("backup write without key");
   // main traffic kinds seen at least once
   cover property (req && we);
   cover property (ack && addr == 16'h0022);
   cover property ($rose(chg_n));
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`include "tsh_map.svh"
module tb_top;
   localparam int TMO = 2000;
   localparam int MS = 10;
   localparam logic [7:0] FAM = 8'h5a; // arbitrary value
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic hid_sel = 1'b0;
   logic touch_active = 1'b0;
   logic [31:0] cfg = 32'h0;
   logic [31:0] seed = 32'h01472a4c;
   logic hid_active, running, cfg_err, acq_pulse, cal_pulse;
   logic ready, fault, cfg_fixed, msg_valid, fault_b;
   logic [55:0] id_info;
   logic [7:0] msg_rid, msg_type, msg_stat, msg_sum, m_rid, m_type, m_stat, m_sum;
   int num_errors = 0;
   int n_compared = 0;
   int n_msg = 0;
   tsh_link_if u_tsh_link_if ();
   tsh_link_if u_tsh_link_if_b ();
   tsh_device #(.POWER_ON_SELF_TEST_CYC(100), .MS_CYC(MS), .FAMILY_ID(FAM)) u_tsh_device (.mclk(mclk),
      .arst_n(arst_n), .lnk(u_tsh_link_if), .hid_sel(hid_sel), .touch_active(touch_active),
      .hid_active(hid_active), .running(running), .cfg_err(cfg_err), .acq_pulse(acq_pulse),
      .cal_pulse(cal_pulse));
   tsh_host #(.TMO_CYC(TMO)) u_tsh_host (.mclk(mclk), .arst_n(arst_n), .lnk(u_tsh_link_if),
      .cfg_bytes(cfg), .ready(ready), .fault(fault), .cfg_fixed(cfg_fixed), .id_info(id_info),
      .msg_valid(msg_valid), .msg_rid(msg_rid), .msg_type(msg_type), .msg_stat(msg_stat),
      .msg_sum(msg_sum));
   // second host faces a dead stub, so only its timeout can end the wait
   tsh_host #(.TMO_CYC(TMO)) u_tsh_host_b (.mclk(mclk), .arst_n(arst_n), .lnk(u_tsh_link_if_b),
      .cfg_bytes(cfg), .ready(), .fault(fault_b), .cfg_fixed(), .id_info(), .msg_valid(),
      .msg_rid(), .msg_type(), .msg_stat(), .msg_sum());
   tsh_link_assertions #(.POWER_ON_SELF_TEST_CYC(100)) u_tsh_link_assertions (.mclk(mclk), .arst_n(arst_n),
      .chg_n(u_tsh_link_if.chg_n), .req(u_tsh_link_if.req), .we(u_tsh_link_if.we),
      .addr(u_tsh_link_if.addr), .wdata(u_tsh_link_if.wdata), .ack(u_tsh_link_if.ack),
      .rdata(u_tsh_link_if.rdata));
   initial begin
      forever #50 mclk = ~mclk;
   end
   // stub never answers; its data toggles so nothing stale looks valid
   initial begin
      u_tsh_link_if_b.chg_n = 1'b1;
      u_tsh_link_if_b.ack = 1'b0;
      u_tsh_link_if_b.rdata = 8'h00;
      forever @(posedge mclk) u_tsh_link_if_b.rdata <= ~u_tsh_link_if_b.rdata;
   end
   // keep the first message after each release
   always @(posedge mclk) begin
      if (msg_valid === 1'b1 && n_msg == 0) begin
         m_rid = msg_rid;
         m_type = msg_type;
         m_stat = msg_stat;
         m_sum = msg_sum;
      end
      if (msg_valid === 1'b1)
         n_msg++;
   end
   function automatic logic [31:0] xs(logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // saved sum starts at zero, so any nonzero sum forces a rewrite
   function automatic logic fix_of(logic [31:0] c);
      logic [7:0] s;
      s = c[7:0] + c[15:8] + c[23:16] + c[31:24];
      return s != 8'h00;
   endfunction
   function automatic int ivl_of(logic [31:0] c, logic ta);
      if (!fix_of(c))
         return 0;
      return ta ? int'(c[15:8]) : int'(c[7:0]);
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize;
      if (num_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic run(logic [31:0] c, logic ta, logic hs);
      int n;
      int gap;
      arst_n = 1'b0;
      cfg = c;
      touch_active = ta;
      hid_sel = hs;
      n_msg = 0;
      repeat (8) @(posedge mclk);
      #1 arst_n = 1'b1;
      n = 0;
      while (ready !== 1'b1 && n < 5000) begin
         @(posedge mclk);
         #1 n++;
      end
      chk("ready", 1, ready);
      chk("fault", 0, fault);
      chk("cfg_fixed", fix_of(c), cfg_fixed);
      chk("id_count", `TSH_NUM_OBJ, id_info[7:0]);
      chk("id_family", FAM, id_info[55:48]);
      chk("hid_active", hs, hid_active);
      chk("cfg_err", 0, cfg_err);
      chk("msg_rid", `TSH_CMD_RID, m_rid);
      chk("msg_type", `TSH_TY_CMD, m_type);
      chk("msg_sum", `TSH_NV_SUM_RST, m_sum);
      chk("msg_cfgerr", 0, m_stat[`TSH_ST_CFGERR]);
      chk("msg_stat", 32'h1 << `TSH_ST_RESET, m_stat);
      chk("n_msg", fix_of(c) ? 2 : 1, n_msg);
      chk("running", 1, running);
      chk("stub_wait", 0, fault_b);
      chk("cal_pulse", 0, cal_pulse);
      // spacing of two pulses; a zero interval must never pulse
      n = 0;
      while (acq_pulse !== 1'b1 && n < 3000) begin
         @(posedge mclk);
         #1 n++;
      end
      gap = 0;
      if (n < 3000) begin
         do begin
            @(posedge mclk);
            #1 gap++;
         end while (acq_pulse !== 1'b1 && gap < 3000);
      end
      chk("acq_gap", ivl_of(c, ta) * MS, gap);
      repeat (TMO) @(posedge mclk);
      #1 chk("stub_fault", 1, fault_b);
      @(posedge mclk);
      #1;
   endtask
   initial begin
      @(posedge mclk);
      #1 run(32'h0, 1'b0, 1'b1);
      run(32'h0100_0300, 1'b0, 1'b0);
      run(32'h0100_0300, 1'b1, 1'b1);
      repeat (3) begin
         seed = xs(seed);
         run(seed, seed[8], seed[9]);
      end
      summarize();
   end
   // six runs stay well below this span
   initial begin
      repeat (80000) @(posedge mclk);
      num_errors++;
      summarize();
   end
endmodule
